/* File: bla_bias_adc_regs.sv */
// How it works
// - Bias limit is seven unsigned bits 6:0, reset zero; bits 15:7 reserved.
// - Bias limit code is the overcurrent detection threshold.
// - Overcurrent fault raised when bias exceeds limit, only while enable is one.
// - Threshold equals code/128 times (range+1) times 9mA step.
// - Source select is three bits 2:0, reset zero; bits 15:3 reserved.
// - Codes 0..5 pick source, modulation, diode volts, monitor, temperature, termination.
// - Current results linear over 1024 codes, scaled by matching range setting.
// - Temperature code is absolute, half degree steps, offset 273.
// - Overcurrent event latched into cleared-on-read status bit 0.
// - Writing source select marks result invalid until a fresh conversion completes.
`timescale 1ns/1ns
`default_nettype none
`include "bla_map.svh"

module bla_bias_adc_regs #(
	parameter int ADC_W = `BLA_ADC_W,
	parameter int LIMIT_W = `BLA_LIMIT_W
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire bla_pkg::bla_req_s regReq,
	output logic [15:0] regRdata,
	output logic regRvalid,
	input wire logic overcurrentEnable,
	input wire logic [ADC_W-1:0] biasCode,
	input wire logic biasCodeValid,
	input wire logic faultStatusRead,
	output logic overcurrentFault,
	output logic overcurrentStatus,
	output logic [LIMIT_W-1:0] biasLimitCode,
	input wire logic userCycle,
	output logic convStart,
	output logic [2:0] convSource,
	input wire logic convDone,
	input wire logic [ADC_W-1:0] convData
);

	logic [LIMIT_W-1:0] limit_reg, limit_next;
	logic [2:0] sel_reg, sel_next;
	logic [15:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic status_reg, status_next;
	logic stale_reg, stale_next;
	logic [2:0] convSrc_reg, convSrc_next;
	bla_pkg::bla_state_e state_reg, state_next;
	bla_pkg::bla_result_s result_reg, result_next;
	logic overLimit;
	logic wrLimit, wrSel, rdSel, rdLimit;

	function automatic logic srcReserved(input logic [2:0] code);
		srcReserved = code >= bla_pkg::BLA_SRC_RSVD6;
	endfunction

	assign wrLimit = regReq.wr && regReq.cmd == `BLA_CMD_BIAS_LIMIT;
	assign wrSel = regReq.wr && regReq.cmd == `BLA_CMD_CONV_SEL;
	assign rdLimit = regReq.rd && regReq.cmd == `BLA_CMD_BIAS_LIMIT;
	assign rdSel = regReq.rd && regReq.cmd == `BLA_CMD_CONV_SEL;

	bla_limit_cmp #(
		.ADC_W(ADC_W),
		.LIMIT_W(LIMIT_W)
	) u_cmp (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.limitCode(limit_reg),
		.sampleCode(biasCode),
		.sampleValid(biasCodeValid),
		.overLimit(overLimit)
	);

	assign overcurrentFault = overLimit && overcurrentEnable;

	// Register file and fault status
	always_comb begin
		limit_next = limit_reg;
		sel_next = sel_reg;
		rdata_next = rdata_reg;
		rvalid_next = 1'b0;
		if (wrLimit) begin
			limit_next = regReq.wdata[LIMIT_W-1:0];
		end
		if (wrSel) begin
			sel_next = regReq.wdata[2:0];
		end
		if (regReq.rd) begin
			rvalid_next = 1'b1;
			rdata_next = 16'h0000;
			if (rdLimit) begin
				rdata_next[LIMIT_W-1:0] = limit_reg;
			end else if (rdSel) begin
				rdata_next[`BLA_RD_SRC_LSB +: 3] = result_reg.src;
				rdata_next[`BLA_RD_VALID_BIT] = result_reg.valid;
				rdata_next[ADC_W-1:0] = result_reg.data;
			end
		end
		// Set wins over the clear so a fault in the read cycle is kept
		status_next = overcurrentFault || (status_reg && !faultStatusRead);
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			limit_reg <= `BLA_LIMIT_RST;
			sel_reg <= `BLA_SEL_RST;
			rdata_reg <= 16'h0000;
			rvalid_reg <= 1'b0;
			status_reg <= 1'b0;
		end else if (clkEn) begin
			limit_reg <= limit_next;
			sel_reg <= sel_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
			status_reg <= status_next;
		end
	end

	// User conversion sequencing
	always_comb begin
		state_next = state_reg;
		convSrc_next = convSrc_reg;
		stale_next = stale_reg;
		result_next = result_reg;
		convStart = 1'b0;
		if (rdSel) begin
			result_next.valid = 1'b0;
		end
		case (state_reg)
			bla_pkg::BLA_IDLE: begin
				if (clkEn && userCycle && !srcReserved(sel_reg)) begin
					convStart = 1'b1;
					convSrc_next = sel_reg;
					stale_next = 1'b0;
					state_next = bla_pkg::BLA_BUSY;
				end
			end
			bla_pkg::BLA_BUSY: begin
				if (convDone) begin
					// Linear and temperature codes pass unscaled; software applies scale
					result_next.src = bla_pkg::bla_src_e'(convSrc_reg);
					result_next.data = convData;
					result_next.valid = !stale_reg && !wrSel;
					state_next = bla_pkg::BLA_IDLE;
				end
			end
			default: begin
				state_next = bla_pkg::BLA_IDLE;
			end
		endcase
		// A conversion started before the write belongs to the old source
		if (wrSel) begin
			result_next.valid = 1'b0;
			stale_next = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_reg <= bla_pkg::BLA_IDLE;
			convSrc_reg <= `BLA_SEL_RST;
			stale_reg <= 1'b0;
			result_reg <= '0;
		end else if (clkEn) begin
			state_reg <= state_next;
			convSrc_reg <= convSrc_next;
			stale_reg <= stale_next;
			result_reg <= result_next;
		end
	end

	assign regRdata = rdata_reg;
	assign regRvalid = rvalid_reg;
	assign overcurrentStatus = status_reg;
	assign biasLimitCode = limit_reg;
	assign convSource = convSrc_reg;

	a_limit_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clkEn && wrLimit |=> limit_reg == $past(regReq.wdata[6:0]))
		else $error("bias limit not loaded from write");
	a_limit_rsvd: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clkEn && (rdLimit || rdSel) |=> regRvalid && regRdata[15] == 1'b0 && (!$past(rdLimit) || regRdata[15:7] == 9'h000))
		else $error("reserved bits read nonzero");
	a_fault_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clkEn && !overcurrentEnable && !overcurrentStatus |=> !overcurrentStatus)
		else $error("status set while fault disabled");
	a_fault_thresh: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clkEn && biasCodeValid && biasCode > {limit_reg, 3'b000} |=> overLimit)
		else $error("bias above limit not detected");
	a_fault_below: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clkEn && biasCodeValid && biasCode <= {limit_reg, 3'b000} |=> !overLimit)
		else $error("bias at or below limit flagged");
	a_status_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clkEn && overcurrentFault |=> overcurrentStatus)
		else $error("overcurrent event lost");
	a_sel_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clkEn && wrSel |=> sel_reg == $past(regReq.wdata[2:0]) && !result_reg.valid)
		else $error("select write mishandled");
	a_rsvd_nostart: assert property (@(posedge sys_clk) disable iff (sys_rst)
		convStart |-> sel_reg < 3'h6 ##1 state_reg == bla_pkg::BLA_BUSY)
		else $error("conversion on reserved source");
	a_result_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clkEn && state_reg == bla_pkg::BLA_BUSY && convDone && !stale_reg && !wrSel
		|=> result_reg.valid && result_reg.data == $past(convData) && result_reg.src == $past(convSrc_reg))
		else $error("fresh result not captured");
	a_read_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clkEn && rdSel && !(state_reg == bla_pkg::BLA_BUSY && convDone) |=> !result_reg.valid)
		else $error("result still valid after read");
	a_status_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clkEn && faultStatusRead && !overcurrentFault |=> !overcurrentStatus)
		else $error("status not cleared by read");
	a_conv_source: assert property (@(posedge sys_clk) disable iff (sys_rst)
		convStart |=> convSource == $past(sel_reg))
		else $error("converted source differs from select");
	// Freeze check also covers the sequencer, which must not advance
	a_freeze_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!clkEn |=> $stable(limit_reg) && $stable(sel_reg) && $stable(state_reg))
		else $error("state moved while clock enable low");

endmodule // bla_bias_adc_regs
`default_nettype wire

/* File: bla_map.svh */
`ifndef BLA_MAP_SVH
`define BLA_MAP_SVH

// Command codes of the two registers
`define BLA_CMD_BIAS_LIMIT 8'h11
`define BLA_CMD_CONV_SEL 8'h18

// Bias limit field
`define BLA_LIMIT_W 7
`define BLA_LIMIT_RST 7'h00

// Conversion source select field
`define BLA_SEL_W 3
`define BLA_SEL_RST 3'h0

// Result layout on read of the select register
`define BLA_ADC_W 10
`define BLA_RD_SRC_LSB 12
`define BLA_RD_VALID_BIT 10

// Limit code steps are 1/128 of full scale, ADC codes 1/1024: ratio 8
`define BLA_LIMIT_SHIFT 3

`endif

/* File: bla_pkg.sv */
`default_nettype none

package bla_pkg;

	typedef enum logic [2:0] {
		BLA_SRC_SOURCE = 3'h0,
		BLA_SRC_MODULATION = 3'h1,
		BLA_SRC_LASER_VOLT = 3'h2,
		BLA_SRC_MONITOR = 3'h3,
		BLA_SRC_TEMP = 3'h4,
		BLA_SRC_TERM_VOLT = 3'h5,
		BLA_SRC_RSVD6 = 3'h6,
		BLA_SRC_RSVD7 = 3'h7
	} bla_src_e;

	typedef enum logic [1:0] {
		BLA_IDLE = 2'h0,
		BLA_BUSY = 2'h1
	} bla_state_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] cmd;
		logic [15:0] wdata;
	} bla_req_s;

	typedef struct packed {
		bla_src_e src;
		logic valid;
		logic [9:0] data;
	} bla_result_s;

endpackage

`default_nettype wire

/* File: bla_limit_cmp.sv */
`timescale 1ns/1ns
`default_nettype none
`include "bla_map.svh"

module bla_limit_cmp #(
	parameter int ADC_W = `BLA_ADC_W,
	parameter int LIMIT_W = `BLA_LIMIT_W
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic [LIMIT_W-1:0] limitCode,
	input wire logic [ADC_W-1:0] sampleCode,
	input wire logic sampleValid,
	output var logic overLimit
);

	logic over_reg;
	logic over_next;
	logic [ADC_W-1:0] threshold;

	// Both scale by the same range setting, so the comparison is range free
	always_comb begin
		threshold = ADC_W'({limitCode, `BLA_LIMIT_SHIFT'(0)});
		over_next = over_reg;
		if (sampleValid) begin
			over_next = sampleCode > threshold;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			over_reg <= 1'b0;
		end else if (clkEn) begin
			over_reg <= over_next;
		end
	end

	assign overLimit = over_reg;

endmodule // bla_limit_cmp
`default_nettype wire

/* File: bla_adc_model.sv */
`timescale 1ns/1ns
`default_nettype none

module bla_adc_model #(
	parameter int LAT = 3,
	parameter logic [9:0] DATA = 10'h2A5
) (
	input wire logic sys_clk,
	input wire logic convStart,
	output logic convDone,
	output logic [9:0] convData
);
	logic [2:0] cntReg = 3'h0;
	always @(posedge sys_clk) begin
		if (convStart) begin
			cntReg <= 3'(LAT);
		end else if (cntReg != 3'h0) begin
			cntReg <= cntReg - 3'h1;
		end
	end
	assign convDone = (cntReg == 3'h1);
	// Inverted outside done so a stale sample never looks right
	assign convData = convDone ? DATA : ~DATA;
endmodule // bla_adc_model

`default_nettype wire

/* File: bias_limit_and_adc_select_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module bias_limit_and_adc_select_tb_top;
	localparam logic [9:0] DATA = 10'h2A5;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	bla_pkg::bla_req_s regReq = '0;
	logic [15:0] regRdata;
	logic regRvalid, oe = 1'b0, bcValid = 1'b0, fsRead = 1'b0, ocFault, ocStatus;
	logic [9:0] biasCode = 10'h000;
	logic [6:0] limitCode;
	logic userCycle = 1'b0, convStart, convDone;
	logic clkEn = 1'b1, lastValid = 1'b0;
	logic [15:0] lastData = 16'h0000;
	logic [2:0] convSource;
	logic [9:0] convData;
	int mismatches = 0, nChecks = 0, cycles = 0;
	logic [7:0] rc[4] = '{8'h11, 8'h11, 8'h11, 8'h22};
	logic [15:0] rw[4] = '{16'hFFFF, 16'h0080, 16'h0055, 16'hABCD};
	logic [15:0] rx[4] = '{16'h007F, 16'h0000, 16'h0055, 16'h0000};
	logic [15:0] rl[4] = '{16'h007F, 16'h0000, 16'h0055, 16'h0055};

	always #5 sys_clk = ~sys_clk;

	bla_bias_adc_regs u_bla_bias_adc_regs (.sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn),
		.regReq(regReq), .regRdata(regRdata), .regRvalid(regRvalid), .overcurrentEnable(oe),
		.biasCode(biasCode), .biasCodeValid(bcValid), .faultStatusRead(fsRead),
		.overcurrentFault(ocFault), .overcurrentStatus(ocStatus), .biasLimitCode(limitCode),
		.userCycle(userCycle), .convStart(convStart), .convSource(convSource),
		.convDone(convDone), .convData(convData));

	bla_adc_model #(.LAT(3), .DATA(DATA)) u_bla_adc_model (.sys_clk(sys_clk),
		.convStart(convStart), .convDone(convDone), .convData(convData));

	task automatic give_verdict();
		if (mismatches == 0 && nChecks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		nChecks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One request over one rising edge, then an idle edge so the strobe never retoggles in a time step
	task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d);
		regReq = '{w, !w, c, d};
		@(negedge sys_clk);
		regReq = '0;
		lastValid = regRvalid;
		lastData = regRdata;
		@(negedge sys_clk);
	endtask

	task automatic rd(input logic [7:0] c, input logic [15:0] exp);
		acc(1'b0, c, 16'h0000);
		chk("rvalid", {15'h0, lastValid}, 16'h0001);
		chk("rdata", lastData, exp);
		chk("rvalidGone", {15'h0, regRvalid}, 16'h0000);
	endtask

	task automatic conv(input logic [2:0] s, input logic expStart);
		userCycle = 1'b1;
		#1 chk("convStart", {15'h0, convStart}, {15'h0, expStart});
		@(negedge sys_clk);
		userCycle = 1'b0;
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			give_verdict();
		end
	end

	initial begin
		repeat (16) @(negedge sys_clk);
		sys_rst = 1'b0;
		chk("limitRst", {9'h0, limitCode}, 16'h0000);
		chk("srcRst", {13'h0, convSource}, 16'h0000);
		rd(8'h11, 16'h0000);
		rd(8'h18, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			acc(1'b1, rc[i], rw[i]);
			chk("limit", {9'h0, limitCode}, rl[i]);
			rd(rc[i], rx[i]);
		end
		// Threshold is code times 8 in bias code steps
		acc(1'b1, 8'h11, 16'h0010);
		oe = 1'b1;
		bcValid = 1'b1;
		biasCode = 10'h080;
		repeat (2) @(negedge sys_clk);
		chk("faultEq", {15'h0, ocFault}, 16'h0000);
		biasCode = 10'h081;
		@(negedge sys_clk);
		chk("fault", {15'h0, ocFault}, 16'h0001);
		biasCode = 10'h000;
		@(negedge sys_clk);
		chk("status", {15'h0, ocStatus}, 16'h0001);
		@(negedge sys_clk);
		chk("faultGone", {15'h0, ocFault}, 16'h0000);
		fsRead = 1'b1;
		@(negedge sys_clk);
		fsRead = 1'b0;
		chk("statusClr", {15'h0, ocStatus}, 16'h0000);
		oe = 1'b0;
		biasCode = 10'h3FF;
		repeat (2) @(negedge sys_clk);
		chk("faultMask", {15'h0, ocFault}, 16'h0000);
		chk("statusMask", {15'h0, ocStatus}, 16'h0000);
		// Event and clear in one cycle: the event must win
		oe = 1'b1;
		fsRead = 1'b1;
		@(negedge sys_clk);
		fsRead = 1'b0;
		oe = 1'b0;
		chk("statusSetWins", {15'h0, ocStatus}, 16'h0001);
		// Source codes 0 to 5, reserved bits set on the write
		for (int s = 0; s < 6; s++) begin
			acc(1'b1, 8'h18, {13'h1FFF, 3'(s)});
			conv(3'(s), 1'b1);
			repeat (6) @(negedge sys_clk);
			chk("convSource", {13'h0, convSource}, 16'(s));
			rd(8'h18, {1'b0, 3'(s), 2'b01, DATA});
			rd(8'h18, {1'b0, 3'(s), 2'b00, DATA});
		end
		acc(1'b1, 8'h18, 16'h0006);
		conv(3'h6, 1'b0);
		acc(1'b1, 8'h18, 16'h0007);
		conv(3'h7, 1'b0);
		acc(1'b1, 8'h18, 16'h0002);
		conv(3'h2, 1'b1);
		acc(1'b1, 8'h18, 16'h0002);
		repeat (6) @(negedge sys_clk);
		rd(8'h18, {4'h2, 2'b00, DATA});
		// Clock enable low freezes writes and conversion starts
		clkEn = 1'b0;
		acc(1'b1, 8'h11, 16'h0033);
		conv(3'h2, 1'b0);
		clkEn = 1'b1;
		chk("frozenLimit", {9'h0, limitCode}, 16'h0010);
		// Reset again in mid-run
		acc(1'b1, 8'h11, 16'h0042);
		sys_rst = 1'b1;
		repeat (2) @(negedge sys_clk);
		sys_rst = 1'b0;
		chk("limitRst2", {9'h0, limitCode}, 16'h0000);
		chk("srcRst2", {13'h0, convSource}, 16'h0000);
		chk("statusRst2", {15'h0, ocStatus}, 16'h0000);
		rd(8'h18, 16'h0000);
		give_verdict();
	end
endmodule // bias_limit_and_adc_select_tb_top

`default_nettype wire
